// *** src/tps_supervisor.sv ***
// Purpose: Three-level thermal protection supervisor
// Assumes: Host strobes and mode inputs are on sys_clk_in; comparators async
// Notes: Cool-down length is a top parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
module tps_supervisor
  import tps_pkg::*;
#(
  parameter int COOL_DOWN_CYCLES = TPS_COOL_DOWN_TIME_US * TPS_CLK_FREQ_MHZ
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire tps_temp_s temp_async_in,
  input wire logic main_supply_on_in,
  input wire logic can_normal_in,
  input wire logic load_share_in,
  input wire logic second_regulator_enable_wr_in,
  input wire logic second_regulator_enable_data_in,
  input wire logic third_regulator_enable_wr_in,
  input wire logic third_regulator_enable_data_in,
  input wire logic high_side_control_wr_in,
  input wire logic [TPS_HS_COUNT-1:0] high_side_control_data_in,
  input wire tps_clear_s clear_in,
  output tps_flags_s flags_out,
  output tps_drive_s drive_out,
  output logic second_regulator_enable_out,
  output logic third_regulator_enable_out,
  output logic [TPS_HS_COUNT-1:0] high_side_control_out,
  output tps_mode_e mode_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    tps_flags_s flags;
    tps_drive_s drive;
    logic second_en;
    logic third_en;
    logic third_hold;
    logic can_tx_off;
    logic [TPS_HS_COUNT-1:0] hs_ctrl;
    tps_mode_e mode;
    logic [TPS_CNT_W-1:0] cnt;
  } tps_state_s;

  localparam logic [TPS_CNT_W-1:0] COOL_LOAD = TPS_CNT_W'(COOL_DOWN_CYCLES - 1);
  localparam logic [TPS_CNT_W-1:0] RESTART_LOAD = TPS_CNT_W'(TPS_RESTART_CYCLES - 1);

  tps_state_s q;
  tps_state_s d;
  tps_temp_s t;
  logic second_hit;
  logic third_hit;
  logic can_hit;
  logic [TPS_HS_COUNT-1:0] hs_hit;
  logic any_ot;
  logic chip_hit;
  logic warn_hit;

  // ----------------------------------------------------------------------
  // Comparator synchronisation
  // ----------------------------------------------------------------------
  tps_sync #(
    .W($bits(tps_temp_s))
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .async_in(temp_async_in),
    .sync_out(t)
  );

  // ----------------------------------------------------------------------
  // Trip qualification
  // ----------------------------------------------------------------------
  always_comb begin
    second_hit = q.second_en & t.second;
    third_hit = q.third_en & ~q.third_hold & t.third;
    can_hit = can_normal_in & ~q.can_tx_off & t.can;
    hs_hit = q.hs_ctrl & t.hs;
    any_ot = t.second | t.third | t.can | (|t.hs);
    chip_hit = main_supply_on_in & t.chip;
    warn_hit = main_supply_on_in & t.prewarn;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    // Host writes; a trip in the same cycle overrides them, except a load-sharing third trip, which keeps the written enable
    if (second_regulator_enable_wr_in) begin
      d.second_en = second_regulator_enable_data_in;
    end
    if (third_regulator_enable_wr_in) begin
      d.third_en = third_regulator_enable_data_in;
    end
    if (high_side_control_wr_in) begin
      d.hs_ctrl = high_side_control_data_in;
    end
    // Clears accepted only when the cause is gone; set below wins
    if (clear_in.first_level && !any_ot) begin
      d.flags.first_level_shutdown_flag = 1'b0;
    end
    if (clear_in.chip_level && !t.chip && q.mode == TPS_NORMAL) begin
      d.flags.chip_level_shutdown_flag = 1'b0;
    end
    if (clear_in.prewarning && !t.prewarn) begin
      d.flags.thermal_prewarning_flag = 1'b0;
    end
    if (clear_in.second_ot && !t.second) begin
      d.flags.second_regulator_overtemp_status = 1'b0;
    end
    if (clear_in.third_ot && !t.third) begin
      d.flags.third_regulator_overtemp_status = 1'b0;
    end
    if (clear_in.can_fail && !t.can) begin
      d.flags.can_fail = TPS_CAN_FAIL_NONE;
    end
    for (int i = 0; i < TPS_HS_COUNT; i++) begin
      if (clear_in.hs_fault[i] && !t.hs[i]) begin
        d.flags.high_side_fault_status[i] = 1'b0;
      end
    end
    // First-level protection per block
    if (second_hit) begin
      d.second_en = 1'b0;
      d.flags.second_regulator_overtemp_status = 1'b1;
    end
    if (third_hit) begin
      d.flags.third_regulator_overtemp_status = 1'b1;
      if (load_share_in) begin
        d.third_hold = 1'b1;
      end else begin
        d.third_en = 1'b0;
      end
    end else if (q.third_hold && !t.third) begin
      d.third_hold = 1'b0;
    end
    if (can_hit) begin
      d.can_tx_off = 1'b1;
      d.flags.can_fail = TPS_CAN_FAIL_OT;
    end else if (q.can_tx_off && !t.can) begin
      d.can_tx_off = 1'b0;
    end
    if (|hs_hit) begin
      d.hs_ctrl = TPS_HS_NONE;
      d.flags.high_side_fault_status = d.flags.high_side_fault_status | hs_hit;
    end
    if (second_hit || third_hit || can_hit || (|hs_hit)) begin
      d.flags.first_level_shutdown_flag = 1'b1;
    end
    if (warn_hit) begin
      d.flags.thermal_prewarning_flag = 1'b1;
    end
    // Chip-level shutdown sequence
    unique case (q.mode)
      TPS_NORMAL: begin
      end
      TPS_FAILSAFE: begin
        if (q.cnt == TPS_CNT_ZERO) begin
          d.mode = TPS_RESTART;
          d.cnt = RESTART_LOAD;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      TPS_RESTART: begin
        if (q.cnt == TPS_CNT_ZERO) begin
          d.mode = TPS_NORMAL;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
    endcase
    if (chip_hit) begin
      d.mode = TPS_FAILSAFE;
      d.cnt = COOL_LOAD;
      d.flags.chip_level_shutdown_flag = 1'b1;
    end
    d.drive.second_regulator_on = d.second_en;
    d.drive.third_regulator_on = d.third_en & ~d.third_hold;
    d.drive.can_transmitter_on = can_normal_in & ~d.can_tx_off;
    d.drive.high_side_switch_on = d.hs_ctrl;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q <= '{flags: '0, drive: '0, second_en: 1'b0, third_en: 1'b0, third_hold: 1'b0,
             can_tx_off: 1'b0, hs_ctrl: TPS_HS_NONE, mode: TPS_NORMAL, cnt: TPS_CNT_ZERO};
    end else begin
      q <= d;
    end
  end

  assign flags_out = q.flags;
  assign drive_out = q.drive;
  assign second_regulator_enable_out = q.second_en;
  assign third_regulator_enable_out = q.third_en;
  assign high_side_control_out = q.hs_ctrl;
  assign mode_out = q.mode;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  property p_second_trip;
    second_hit |=> !q.second_en && q.flags.second_regulator_overtemp_status
      && q.flags.first_level_shutdown_flag && !drive_out.second_regulator_on;
  endproperty
  a_second_trip: assert property (p_second_trip)
    else $error("second regulator trip not handled");

  property p_first_level_cause;
    $rose(q.flags.first_level_shutdown_flag) |->
      $past(second_hit || third_hit || can_hit || (|hs_hit));
  endproperty
  a_first_level_cause: assert property (p_first_level_cause)
    else $error("first-level flag set without an enabled block trip");

  property p_first_level_refused;
    q.flags.first_level_shutdown_flag && clear_in.first_level && any_ot
      |=> q.flags.first_level_shutdown_flag;
  endproperty
  a_first_level_refused: assert property (p_first_level_refused)
    else $error("first-level flag cleared while hot");

  property p_third_share;
    third_hit && load_share_in |=> q.third_hold && q.third_en && !drive_out.third_regulator_on;
  endproperty
  a_third_share: assert property (p_third_share)
    else $error("load-sharing third regulator hold wrong");

  property p_third_release;
    q.third_hold && !t.third |=> !q.third_hold && drive_out.third_regulator_on == q.third_en;
  endproperty
  a_third_release: assert property (p_third_release)
    else $error("load-sharing third regulator not restarted");

  property p_can_trip;
    can_hit |=> q.flags.can_fail == TPS_CAN_FAIL_OT && !drive_out.can_transmitter_on;
  endproperty
  a_can_trip: assert property (p_can_trip)
    else $error("CAN trip not handled");

  property p_hs_trip;
    (|hs_hit) |=> q.hs_ctrl == TPS_HS_NONE
      && (q.flags.high_side_fault_status & $past(hs_hit)) == $past(hs_hit);
  endproperty
  a_hs_trip: assert property (p_hs_trip)
    else $error("high-side trip not handled");

  property p_chip_trip;
    chip_hit |=> q.mode == TPS_FAILSAFE && q.flags.chip_level_shutdown_flag && q.cnt == COOL_LOAD;
  endproperty
  a_chip_trip: assert property (p_chip_trip)
    else $error("chip-level trip did not start cool-down");

  property p_chip_clear_mode;
    q.flags.chip_level_shutdown_flag && clear_in.chip_level && q.mode != TPS_NORMAL
      |=> q.flags.chip_level_shutdown_flag;
  endproperty
  a_chip_clear_mode: assert property (p_chip_clear_mode)
    else $error("chip-level flag cleared outside normal mode");

  property p_prewarn_cause;
    $rose(q.flags.thermal_prewarning_flag) |-> $past(main_supply_on_in && t.prewarn);
  endproperty
  a_prewarn_cause: assert property (p_prewarn_cause)
    else $error("prewarning flag set while main supply off");

  property p_restart_exit;
    q.mode == TPS_RESTART && q.cnt == TPS_CNT_ZERO && !chip_hit |=> q.mode == TPS_NORMAL;
  endproperty
  a_restart_exit: assert property (p_restart_exit)
    else $error("restart did not return to normal");

endmodule
`default_nettype wire

// *** src/tps_pkg.sv ***
// Purpose: Shared constants and carriers of the thermal protection supervisor
// Assumes: 100 MHz system clock
// Notes: Comparator bundles and flag groups travel as packed structs
package tps_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int TPS_CLK_FREQ_MHZ = 100;
  localparam int TPS_COOL_DOWN_TIME_US = 1000;
  localparam int TPS_RESTART_TIME_US = 2;
  localparam int TPS_RESTART_CYCLES = TPS_RESTART_TIME_US * TPS_CLK_FREQ_MHZ;
  localparam int TPS_CNT_W = 32;

  // ----------------------------------------------------------------------
  // Fields and encodings
  // ----------------------------------------------------------------------
  localparam int TPS_HS_COUNT = 4;
  localparam logic [1:0] TPS_CAN_FAIL_NONE = 2'h0;
  localparam logic [1:0] TPS_CAN_FAIL_OT = 2'h1;
  localparam logic [TPS_HS_COUNT-1:0] TPS_HS_NONE = 4'h0;
  localparam logic [TPS_CNT_W-1:0] TPS_CNT_ZERO = 32'h0;

  typedef enum logic [1:0] {
    TPS_NORMAL,
    TPS_FAILSAFE,
    TPS_RESTART
  } tps_mode_e;

  // Raw or synchronised comparator outputs, one bit per block
  typedef struct packed {
    logic chip;
    logic prewarn;
    logic [TPS_HS_COUNT-1:0] hs;
    logic can;
    logic third;
    logic second;
  } tps_temp_s;

  // Host clear strobes, one cycle each
  typedef struct packed {
    logic first_level;
    logic chip_level;
    logic prewarning;
    logic second_ot;
    logic third_ot;
    logic can_fail;
    logic [TPS_HS_COUNT-1:0] hs_fault;
  } tps_clear_s;

  // Sticky diagnostic flags
  typedef struct packed {
    logic first_level_shutdown_flag;
    logic chip_level_shutdown_flag;
    logic thermal_prewarning_flag;
    logic second_regulator_overtemp_status;
    logic third_regulator_overtemp_status;
    logic [1:0] can_fail;
    logic [TPS_HS_COUNT-1:0] high_side_fault_status;
  } tps_flags_s;

  // Output stage drive levels
  typedef struct packed {
    logic second_regulator_on;
    logic third_regulator_on;
    logic can_transmitter_on;
    logic [TPS_HS_COUNT-1:0] high_side_switch_on;
  } tps_drive_s;

endpackage

// *** src/tps_sync.sv ***
// Purpose: Two-stage synchroniser for a bundle of asynchronous levels
// Assumes: Inputs are slow levels, no multi-bit coherence needed
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module tps_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } tps_sync_s;

  tps_sync_s q;
  tps_sync_s d;

  always_comb begin
    d.meta = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;

endmodule
`default_nettype wire

// *** verification/tps_host_model.sv ***
// Purpose: Host side model issuing enable writes and flag clears
// Assumes: Tasks are called at a falling edge of sys_clk_in
// Notes: Data lines show inverted garbage once a strobe is released
`timescale 1ns/1ps
`default_nettype none
module tps_host_model
  import tps_pkg::*;
(
  input wire logic sys_clk_in,
  output logic sec_wr_out,
  output logic sec_data_out,
  output logic thr_wr_out,
  output logic thr_data_out,
  output logic hs_wr_out,
  output logic [TPS_HS_COUNT-1:0] hs_data_out,
  output tps_clear_s clear_out
);
  // ----------------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------------
  initial begin
    sec_wr_out = 1'h0;
    sec_data_out = 1'h0;
    thr_wr_out = 1'h0;
    thr_data_out = 1'h0;
    hs_wr_out = 1'h0;
    hs_data_out = 4'h0;
    clear_out = '0;
  end

  // ----------------------------------------------------------------------
  // One-cycle write and clear strobes
  // ----------------------------------------------------------------------
  task write_second(input logic d);
    sec_wr_out = 1'h1;
    sec_data_out = d;
    @(negedge sys_clk_in);
    sec_wr_out = 1'h0;
    sec_data_out = ~d;
  endtask

  task write_third(input logic d);
    thr_wr_out = 1'h1;
    thr_data_out = d;
    @(negedge sys_clk_in);
    thr_wr_out = 1'h0;
    thr_data_out = ~d;
  endtask

  task write_hs(input logic [TPS_HS_COUNT-1:0] d);
    hs_wr_out = 1'h1;
    hs_data_out = d;
    @(negedge sys_clk_in);
    hs_wr_out = 1'h0;
    hs_data_out = ~d;
  endtask

  task clear(input tps_clear_s c);
    clear_out = c;
    @(negedge sys_clk_in);
    clear_out = '0;
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Purpose: Self-checking bench of the thermal protection supervisor
// Assumes: Cool-down shortened to 20 cycles
// Notes: Inputs change at falling edges only
`timescale 1ns/1ps
`default_nettype none
module tb
  import tps_pkg::*;
;
  logic sys_clk, rst, main_on, can_norm, load_share;
  tps_temp_s tmp;
  logic sec_wr, sec_d, thr_wr, thr_d, hs_wr, sec_en, thr_en;
  logic [3:0] hs_d, hs_ctl;
  tps_clear_s clr;
  tps_flags_s flags;
  tps_drive_s drive;
  tps_mode_e mode;
  int num_errors = 0;
  int n_compared = 0;

  tps_supervisor #(.COOL_DOWN_CYCLES(20)) i_dut (
    .sys_clk_in(sys_clk), .rst_in(rst), .temp_async_in(tmp),
    .main_supply_on_in(main_on), .can_normal_in(can_norm), .load_share_in(load_share),
    .second_regulator_enable_wr_in(sec_wr), .second_regulator_enable_data_in(sec_d),
    .third_regulator_enable_wr_in(thr_wr), .third_regulator_enable_data_in(thr_d),
    .high_side_control_wr_in(hs_wr), .high_side_control_data_in(hs_d), .clear_in(clr),
    .flags_out(flags), .drive_out(drive), .second_regulator_enable_out(sec_en),
    .third_regulator_enable_out(thr_en), .high_side_control_out(hs_ctl), .mode_out(mode));

  tps_host_model i_host (
    .sys_clk_in(sys_clk), .sec_wr_out(sec_wr), .sec_data_out(sec_d), .thr_wr_out(thr_wr),
    .thr_data_out(thr_d), .hs_wr_out(hs_wr), .hs_data_out(hs_d), .clear_out(clr));

  // ----------------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    tmp = '0;
    main_on = 1'h0;
    can_norm = 1'h0;
    load_share = 1'h0;
    rst = 1'h1;
    cyc(6);
    rst = 1'h0;
    check("flags_reset", flags, 11'h000);
    check("mode_reset", mode, TPS_NORMAL);
    tmp.second = 1'h1;
    cyc(4);
    check("flags_block_off", flags, 11'h000);
    tmp.second = 1'h0;
    cyc(3);
    i_host.write_second(1'h1);
    check("second_on", drive.second_regulator_on, 1'h1);
    tmp.second = 1'h1;
    cyc(2);
    check("second_sync", flags.second_regulator_overtemp_status, 1'h0);
    cyc(1);
    check("second_status", flags.second_regulator_overtemp_status, 1'h1);
    check("first_flag", flags.first_level_shutdown_flag, 1'h1);
    check("second_en", sec_en, 1'h0);
    check("second_drive", drive.second_regulator_on, 1'h0);
    i_host.clear(10'h240);
    check("first_hot_clear", flags.first_level_shutdown_flag, 1'h1);
    check("second_hot_clear", flags.second_regulator_overtemp_status, 1'h1);
    tmp.second = 1'h0;
    cyc(5);
    check("first_sticky", flags.first_level_shutdown_flag, 1'h1);
    i_host.clear(10'h240);
    check("first_cleared", flags.first_level_shutdown_flag, 1'h0);
    check("second_cleared", flags.second_regulator_overtemp_status, 1'h0);
    i_host.write_third(1'h1);
    tmp.third = 1'h1;
    cyc(3);
    check("third_sa_en", thr_en, 1'h0);
    check("third_sa_status", flags.third_regulator_overtemp_status, 1'h1);
    tmp.third = 1'h0;
    cyc(3);
    i_host.clear(10'h020);
    check("third_status_clr", flags.third_regulator_overtemp_status, 1'h0);
    i_host.write_third(1'h1);
    check("third_reon", drive.third_regulator_on, 1'h1);
    load_share = 1'h1;
    tmp.third = 1'h1;
    cyc(3);
    check("third_ls_drive", drive.third_regulator_on, 1'h0);
    check("third_ls_en", thr_en, 1'h1);
    check("third_ls_status", flags.third_regulator_overtemp_status, 1'h1);
    tmp.third = 1'h0;
    cyc(3);
    check("third_ls_back", drive.third_regulator_on, 1'h1);
    check("third_ls_sticky", flags.third_regulator_overtemp_status, 1'h1);
    can_norm = 1'h1;
    cyc(1);
    check("can_tx_on", drive.can_transmitter_on, 1'h1);
    tmp.can = 1'h1;
    cyc(3);
    check("can_fail", flags.can_fail, TPS_CAN_FAIL_OT);
    check("can_tx_off", drive.can_transmitter_on, 1'h0);
    tmp.can = 1'h0;
    cyc(3);
    check("can_tx_back", drive.can_transmitter_on, 1'h1);
    check("can_fail_sticky", flags.can_fail, TPS_CAN_FAIL_OT);
    i_host.write_hs(4'hF);
    check("hs_on", drive.high_side_switch_on, 4'hF);
    tmp.hs = 4'h4;
    cyc(3);
    check("hs_ctl", hs_ctl, 4'h0);
    check("hs_drive", drive.high_side_switch_on, 4'h0);
    check("hs_fault", flags.high_side_fault_status, 4'h4);
    tmp.hs = 4'h0;
    cyc(3);
    i_host.clear(10'h00F);
    check("hs_fault_clr", flags.high_side_fault_status, 4'h0);
    tmp.prewarn = 1'h1;
    cyc(4);
    check("prewarn_off", flags.thermal_prewarning_flag, 1'h0);
    main_on = 1'h1;
    cyc(3);
    check("prewarn_set", flags.thermal_prewarning_flag, 1'h1);
    check("prewarn_mode", mode, TPS_NORMAL);
    i_host.clear(10'h080);
    check("prewarn_hot_clr", flags.thermal_prewarning_flag, 1'h1);
    tmp.prewarn = 1'h0;
    cyc(3);
    i_host.clear(10'h080);
    check("prewarn_clr", flags.thermal_prewarning_flag, 1'h0);
    main_on = 1'h0;
    tmp.chip = 1'h1;
    cyc(1);
    tmp.chip = 1'h0;
    cyc(4);
    check("chip_off_mode", mode, TPS_NORMAL);
    check("chip_off_flag", flags.chip_level_shutdown_flag, 1'h0);
    main_on = 1'h1;
    tmp.chip = 1'h1;
    cyc(1);
    tmp.chip = 1'h0;
    cyc(2);
    check("chip_failsafe", mode, TPS_FAILSAFE);
    check("chip_flag", flags.chip_level_shutdown_flag, 1'h1);
    cyc(19);
    check("cool_down_end", mode, TPS_FAILSAFE);
    cyc(1);
    check("restart", mode, TPS_RESTART);
    i_host.clear(10'h100);
    check("chip_clr_restart", flags.chip_level_shutdown_flag, 1'h1);
    cyc(198);
    check("restart_end", mode, TPS_RESTART);
    cyc(1);
    check("normal", mode, TPS_NORMAL);
    i_host.clear(10'h100);
    check("chip_clr", flags.chip_level_shutdown_flag, 1'h0);
    tmp.hs = 4'h1;
    cyc(4);
    check("hs_off_fault", flags.high_side_fault_status, 4'h0);
    check("hs_off_first", flags.first_level_shutdown_flag, 1'h1);
    tmp.hs = 4'h0;
    rst = 1'h1;
    cyc(2);
    rst = 1'h0;
    load_share = 1'h0;
    can_norm = 1'h0;
    check("flags_rerst", flags, 11'h000);
    check("drive_rerst", drive, 7'h00);
    check("thr_en_rerst", thr_en, 1'h0);
    tmp.can = 1'h1;
    cyc(4);
    check("can_off_fail", flags.can_fail, TPS_CAN_FAIL_NONE);
    check("can_off_first", flags.first_level_shutdown_flag, 1'h0);
    check("can_off_tx", drive.can_transmitter_on, 1'h0);
    tmp.can = 1'h0;
    end_sim();
  end
endmodule
`default_nettype wire
